// ===== logic/psbe_top.sv
// Port status byte encoder with AHB-Lite register slave
//
// Function
// RQ1 - Each of the eight ports has exactly one status byte in the input process image.
// RQ2 - Low nibble is 0 for a disabled port, 1 for digital input and 2 for digital output.
// RQ3 - Low nibble is 3 while the link is operating and 4 when link traffic is stopped.
// RQ4 - High nibble carries the port error code from 0x0 to 0xB, 0 meaning no error.
// RQ5 - The unread flag is 0 after the newest message is read and 1 while unread.
// RQ6 - The pending flag is 1 while unacknowledged messages exist, else 0.
// RQ7 - Time messages are forwarded and the device can act as reference clock.
// RQ8 - Network time stamps live in a 32-bit counter that wraps.
// RQ9 - Port sampling runs freely and is never aligned to network time events.
// RQ10 - Up to 250 messages are kept in a ring that overwrites from the first slot.
// RQ11 - A stored message sets the unread flag; reading the newest clears it.
`timescale 1ns/1ps
`default_nettype none
module psbe_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] link_operating,
  input wire logic [31:0] port_error_code,
  input wire logic diag_push,
  input wire logic [31:0] diag_msg,
  input wire logic time_msg_in,
  input wire logic [31:0] time_msg_value,
  output logic time_msg_out,
  output logic [31:0] time_msg_fwd,
  output logic [63:0] input_process_image,
  output logic [1:0] diag_flags,
  output logic irq
);
  localparam int IRQ_W = psbe_pkg::IRQ_BITS;
  psbe_pkg::psbe_bus_t bus_st, next_bus_st;
  logic [7:0] addr_q, next_addr_q;
  logic [31:0] next_hrdata;
  logic [23:0] port_mode, next_port_mode;
  logic [1:0] time_ctrl, next_time_ctrl;
  logic [31:0] net_time, next_net_time;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [63:0] next_image;
  logic next_time_out;
  logic [31:0] next_time_fwd;
  logic [31:0] err_prev;
  logic rd_newest, ack_one;
  logic [31:0] newest_msg;
  logic unread_newest, ack_pending;
  logic [7:0] msg_count;

  // ---------------------------------------------------------------
  // Status byte encoding
  // ---------------------------------------------------------------

  // One status byte from mode, link state and error code
  function automatic logic [7:0] status_byte(input logic [2:0] mode, input logic op,
                                             input logic [3:0] err);
    logic [3:0] st;
    st = psbe_pkg::ST_DISABLED; // RQ2
    unique case (mode)
      psbe_pkg::MODE_SIO_IN: st = psbe_pkg::ST_SIO_IN; // RQ2
      psbe_pkg::MODE_SIO_OUT: st = psbe_pkg::ST_SIO_OUT; // RQ2
      psbe_pkg::MODE_LINK: st = op ? psbe_pkg::ST_LINK_OP : psbe_pkg::ST_LINK_STOP; // RQ3
      default: st = psbe_pkg::ST_DISABLED;
    endcase
    // Out-of-table codes are clamped so the master never sees junk
    status_byte = {(err > psbe_pkg::ERR_MAX) ? psbe_pkg::ERR_MAX : err, st}; // RQ4
  endfunction

  // Each port is sampled every cycle, free of time events
  generate
    for (genvar p = 0; p < psbe_pkg::NUM_PORTS; p++) begin : g_port
      assign next_image[8*p +: 8] = status_byte(port_mode[3*p +: 3], link_operating[p],
                                                port_error_code[4*p +: 4]); // RQ1 RQ9
    end
  endgenerate

  // ---------------------------------------------------------------
  // Diagnostic ring
  // ---------------------------------------------------------------

  psbe_diag_ring u_ring (
    .clk(clk),
    .rst_b(rst_b),
    .push(diag_push),
    .push_msg(diag_msg),
    .read_newest(rd_newest),
    .ack_one(ack_one),
    .newest_msg(newest_msg),
    .unread_newest(unread_newest),
    .ack_pending(ack_pending),
    .msg_count(msg_count)
  );

  // ---------------------------------------------------------------
  // Network time
  // ---------------------------------------------------------------

  // Reference mode counts locally, otherwise adopts received time
  always_comb begin
    next_net_time = net_time + psbe_pkg::TIME_STEP; // RQ8
    if (time_msg_in && !time_ctrl[psbe_pkg::TC_REF]) begin
      next_net_time = time_msg_value;
    end
    next_time_out = 1'b0;
    next_time_fwd = time_msg_fwd;
    if (time_msg_in && time_ctrl[psbe_pkg::TC_FWD]) begin
      next_time_out = 1'b1; // RQ7
      next_time_fwd = time_msg_value;
    end else if (time_ctrl[psbe_pkg::TC_REF] && next_net_time < net_time) begin
      // As reference, emit own time once per counter wrap
      next_time_out = 1'b1; // RQ7
      next_time_fwd = next_net_time;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------

  // Address phase capture, write decode, read data and interrupts
  always_comb begin
    next_bus_st = psbe_pkg::PSBE_IDLE;
    next_addr_q = addr_q;
    next_port_mode = port_mode;
    next_time_ctrl = time_ctrl;
    next_irq_mask = irq_mask;
    next_hrdata = 32'h0000_0000;
    rd_newest = 1'b0;
    ack_one = 1'b0;
    next_irq_stat = irq_stat;
    if (bus_st == psbe_pkg::PSBE_WRITE) begin
      unique case (addr_q)
        psbe_pkg::OFS_MODE: next_port_mode = hwdata[23:0];
        psbe_pkg::OFS_DIAG_ACK: ack_one = hwdata[0]; // RQ6
        psbe_pkg::OFS_TIME_CTRL: next_time_ctrl = hwdata[1:0];
        psbe_pkg::OFS_IRQ_MASK: next_irq_mask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (bus_st == psbe_pkg::PSBE_READ) begin
      if (addr_q == psbe_pkg::OFS_DIAG_NEWEST) rd_newest = 1'b1; // RQ5 RQ11
      if (addr_q == psbe_pkg::OFS_IRQ_STATUS) next_irq_stat = '0;
    end
    // Events set after the read clear, so a coincident event survives
    if (diag_push) next_irq_stat[psbe_pkg::IRQ_NEW_DIAG] = 1'b1;
    if (port_error_code != err_prev) next_irq_stat[psbe_pkg::IRQ_ERR_CHANGE] = 1'b1;
    if (next_net_time < net_time) next_irq_stat[psbe_pkg::IRQ_TIME_WRAP] = 1'b1;
    if (hsel && hready && htrans == psbe_pkg::HTRANS_NONSEQ) begin
      next_addr_q = haddr[7:0];
      next_bus_st = hwrite ? psbe_pkg::PSBE_WRITE : psbe_pkg::PSBE_READ;
      if (!hwrite) begin
        unique case (haddr[7:0])
          psbe_pkg::OFS_STATUS_LO: next_hrdata = input_process_image[31:0];
          psbe_pkg::OFS_STATUS_HI: next_hrdata = input_process_image[63:32];
          psbe_pkg::OFS_MODE: next_hrdata = {8'h00, port_mode};
          psbe_pkg::OFS_DIAG_FLAGS: next_hrdata = {30'h0, ack_pending, unread_newest};
          psbe_pkg::OFS_DIAG_NEWEST: next_hrdata = newest_msg;
          psbe_pkg::OFS_TIME: next_hrdata = net_time;
          psbe_pkg::OFS_TIME_CTRL: next_hrdata = {30'h0, time_ctrl};
          psbe_pkg::OFS_IRQ_STATUS: next_hrdata = {29'h0, irq_stat};
          psbe_pkg::OFS_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
          psbe_pkg::OFS_DIAG_COUNT: next_hrdata = {24'h0, msg_count};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // All state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_st <= psbe_pkg::PSBE_IDLE;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      port_mode <= 24'h00_0000;
      time_ctrl <= 2'h0;
      net_time <= 32'h0000_0000;
      irq_stat <= '0;
      irq_mask <= '0;
      err_prev <= 32'h0000_0000;
      time_msg_out <= 1'b0;
      time_msg_fwd <= 32'h0000_0000;
      input_process_image <= 64'h0;
      diag_flags <= 2'h0;
      irq <= 1'b0;
    end else begin
      bus_st <= next_bus_st;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      port_mode <= next_port_mode;
      time_ctrl <= next_time_ctrl;
      net_time <= next_net_time; // RQ8
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      err_prev <= port_error_code;
      time_msg_out <= next_time_out;
      time_msg_fwd <= next_time_fwd;
      input_process_image <= next_image; // RQ1
      diag_flags <= {ack_pending, unread_newest}; // RQ5 RQ6
      irq <= |(next_irq_stat & next_irq_mask);
    end
  end
endmodule
`default_nettype wire

// ===== logic/psbe_pkg.sv
// Package of constants and types for the port status byte encoder
package psbe_pkg;
  localparam int NUM_PORTS = 8;
  localparam int DIAG_DEPTH = 250;
  localparam logic [7:0] DIAG_LAST = 8'hF9;
  // Port state nibble codes
  localparam logic [3:0] ST_DISABLED = 4'h0;
  localparam logic [3:0] ST_SIO_IN = 4'h1;
  localparam logic [3:0] ST_SIO_OUT = 4'h2;
  localparam logic [3:0] ST_LINK_OP = 4'h3;
  localparam logic [3:0] ST_LINK_STOP = 4'h4;
  // Port mode configuration codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SIO_IN = 3'h1;
  localparam logic [2:0] MODE_SIO_OUT = 3'h2;
  localparam logic [2:0] MODE_LINK = 3'h3;
  // Error code nibble, highest legal value
  localparam logic [3:0] ERR_MAX = 4'hB;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS_LO = 8'h00;
  localparam logic [7:0] OFS_STATUS_HI = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_DIAG_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_DIAG_NEWEST = 8'h10;
  localparam logic [7:0] OFS_DIAG_ACK = 8'h14;
  localparam logic [7:0] OFS_TIME = 8'h18;
  localparam logic [7:0] OFS_TIME_CTRL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_DIAG_COUNT = 8'h28;
  // Interrupt status bits
  localparam int IRQ_NEW_DIAG = 0;
  localparam int IRQ_ERR_CHANGE = 1;
  localparam int IRQ_TIME_WRAP = 2;
  localparam int IRQ_BITS = 3;
  // Time control bits
  localparam int TC_REF = 0;
  localparam int TC_FWD = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] TIME_STEP = 32'h0000_0032;
  typedef enum logic [2:0] {
    PSBE_IDLE = 3'b001,
    PSBE_WRITE = 3'b010,
    PSBE_READ = 3'b100
  } psbe_bus_t;
endpackage

// ===== logic/psbe_diag_ring.sv
// Diagnostic message ring with newest and pending tracking
`timescale 1ns/1ps
`default_nettype none
module psbe_diag_ring (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [31:0] push_msg,
  input wire logic read_newest,
  input wire logic ack_one,
  output logic [31:0] newest_msg,
  output logic unread_newest,
  output logic ack_pending,
  output logic [7:0] msg_count
);
  logic [31:0] ring [psbe_pkg::DIAG_DEPTH];
  logic [7:0] wr_ptr, next_wr_ptr, last_ptr, next_last_ptr;
  logic [7:0] next_msg_count;
  logic [7:0] unacked, next_unacked;
  logic next_unread;

  // Ring pointer, fill count and flag update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_last_ptr = last_ptr;
    next_msg_count = msg_count;
    next_unacked = unacked;
    next_unread = unread_newest;
    if (read_newest) begin
      next_unread = 1'b0; // RQ5
    end
    if (ack_one && unacked != 8'h00) begin
      next_unacked = unacked - 8'h01; // RQ6
    end
    if (push) begin
      next_last_ptr = wr_ptr;
      // Wrap back to the first slot once full
      next_wr_ptr = (wr_ptr == psbe_pkg::DIAG_LAST) ? 8'h00 : wr_ptr + 8'h01; // RQ10
      if (msg_count != psbe_pkg::DIAG_LAST + 8'h01) begin
        next_msg_count = msg_count + 8'h01;
      end
      // Overwritten messages can no longer be acknowledged
      if (next_unacked != psbe_pkg::DIAG_LAST + 8'h01) begin
        next_unacked = next_unacked + 8'h01;
      end
      next_unread = 1'b1; // RQ11
    end
  end

  // Registers; a push in the read cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 8'h00;
      last_ptr <= 8'h00;
      msg_count <= 8'h00;
      unacked <= 8'h00;
      unread_newest <= 1'b0;
      ack_pending <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      last_ptr <= next_last_ptr;
      msg_count <= next_msg_count;
      unacked <= next_unacked;
      unread_newest <= next_unread;
      ack_pending <= (next_unacked != 8'h00); // RQ6
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      ring[wr_ptr] <= push_msg; // RQ10
    end
  end

  assign newest_msg = ring[last_ptr];
endmodule
`default_nettype wire

// ===== tb/psbe_props.sv
// Checker for bus answers, status image and event flags
`timescale 1ns/1ps
`default_nettype none
module psbe_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] port_error_code,
  input wire logic diag_push,
  input wire logic time_msg_out,
  input wire logic [31:0] time_msg_fwd,
  input wire logic [63:0] input_process_image,
  input wire logic [1:0] diag_flags
);
  logic up;
  // ----
  // Helpers
  // ----
  // Masks the first edge, where the past input predates reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) up <= 1'b0;
    else up <= 1'b1;
  end
  function automatic logic [3:0] cl(input logic [3:0] e);
    return (e > 4'hB) ? 4'hB : e;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  okay_resp_a: assert property (!hresp) else $error("error response seen");
  rdata_idle_a: assert property (
    !(hsel && hready && htrans == 2'h2 && !hwrite) |=> hrdata == 32'h0)
    else $error("read data without read");
  err_low_a: assert property (
    up |-> input_process_image[7:4] == cl($past(port_error_code[3:0])))
    else $error("port 0 error nibble wrong");
  err_high_a: assert property (
    up |-> input_process_image[63:60] == cl($past(port_error_code[31:28])))
    else $error("port 7 error nibble wrong");
  state_legal_a: assert property (
    input_process_image[3:0] <= 4'h4 && input_process_image[59:56] <= 4'h4)
    else $error("illegal state nibble");
  unread_set_a: assert property (diag_push |-> ##[1:2] diag_flags[0])
    else $error("unread not set");
  pend_set_a: assert property (diag_push |-> ##[1:2] diag_flags[1])
    else $error("pending not set");
  fwd_pulse_a: assert property ($changed(time_msg_fwd) |-> time_msg_out)
    else $error("forward value moved without pulse");
endmodule
bind psbe_top psbe_props u_psbe_props (.clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .port_error_code(port_error_code), .diag_push(diag_push), .time_msg_out(time_msg_out),
  .time_msg_fwd(time_msg_fwd), .input_process_image(input_process_image), .diag_flags(diag_flags));
`default_nettype wire

// ===== tb/psbe_fb_model.sv
// Fieldbus master model reading the input image cyclically
`timescale 1ns/1ps
`default_nettype none
module psbe_fb_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [63:0] image,
  output logic [63:0] seen
);
  // One status byte per port taken every cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) seen <= 64'h0;
    else seen <= image;
  end
endmodule
`default_nettype wire

// ===== tb/psbe_top_tb.sv
// Self-checking bench for the port status byte encoder
`timescale 1ns/1ps
`default_nettype none
module psbe_top_tb;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, diag_push = 1'b0, time_msg_in = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, port_error_code = '0, diag_msg = '0, time_msg_value = '0;
  logic [31:0] rnd = 32'h0000005D, hrdata, time_msg_fwd;
  logic [1:0] htrans = 2'h0, diag_flags;
  logic [2:0] hsize = 3'h2;
  logic [7:0] link_operating = 8'h00;
  logic hreadyout, hresp, time_msg_out, irq, dph_rd = 1'b0;
  logic [63:0] input_process_image, seen, ex;
  logic [32:0] exp_q[$], e;
  logic [23:0] md;
  localparam logic [32:0] IGN = 33'h100000000;
  int err_total = 0, compares = 0;
  always #25 clk = ~clk;
  psbe_top u_psbe_top (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_operating(link_operating),
    .port_error_code(port_error_code), .diag_push(diag_push), .diag_msg(diag_msg),
    .time_msg_in(time_msg_in), .time_msg_value(time_msg_value), .time_msg_out(time_msg_out),
    .time_msg_fwd(time_msg_fwd), .input_process_image(input_process_image),
    .diag_flags(diag_flags), .irq(irq));
  psbe_fb_model u_psbe_fb_model (.clk(clk), .rst_b(rst_b), .image(input_process_image),
    .seen(seen));
  // ----
  // Tasks
  // ----
  task check(input logic [63:0] s, input logic [63:0] x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task stop_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Single word transfer; an idle edge after it lets register effects land
  task bus(input logic w, input logic [7:0] a, input logic [32:0] x, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    if (!w) exp_q.push_back(x);
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
  endtask
  task push(input logic [31:0] m);
    diag_msg <= m;
    diag_push <= 1'b1;
    @(posedge clk);
    diag_push <= 1'b0;
    @(posedge clk);
  endtask
  task tmsg(input logic [31:0] v);
    time_msg_value <= v;
    time_msg_in <= 1'b1;
    @(posedge clk);
    time_msg_in <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] sb(input logic [2:0] m, input logic l, input logic [3:0] r);
    return {(r > 4'hB) ? 4'hB : r, (m == 3'h3) ? (l ? 4'h3 : 4'h4) : {1'b0, m}};
  endfunction
  // Read data monitor, oldest expectation first
  always @(posedge clk) begin
    if (dph_rd && hreadyout === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[32]) check({32'h0, hrdata}, {32'h0, e[31:0]});
    end
    dph_rd <= hsel && hreadyout && htrans == 2'h2 && !hwrite;
  end
  // Watchdog sized well past the longest run
  initial begin
    #1000000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      rnd = nx(nx(rnd));
      port_error_code <= rnd;
      link_operating <= rnd[15:8];
      md = (k == 0) ? 24'h0 : (k == 1) ? 24'h688688 : rnd[23:0] & 24'h6DB6DB;
      bus(1'b1, psbe_pkg::OFS_MODE, IGN, {8'h00, md});
      bus(1'b0, psbe_pkg::OFS_MODE, {9'h0, md}, 32'h0);
      for (int p = 0; p < 8; p++) begin
        ex[8*p+:8] = sb(md[3*p+:3], link_operating[p], port_error_code[4*p+:4]);
      end
      bus(1'b0, psbe_pkg::OFS_STATUS_LO, {1'b0, ex[31:0]}, 32'h0);
      bus(1'b0, psbe_pkg::OFS_STATUS_HI, {1'b0, ex[63:32]}, 32'h0);
      check(seen, ex);
    end
    bus(1'b0, psbe_pkg::OFS_IRQ_STATUS, IGN, 32'h0);
    bus(1'b1, psbe_pkg::OFS_IRQ_MASK, IGN, 32'h1);
    push(32'hA5A50001);
    repeat (3) @(posedge clk);
    check({63'h0, irq}, 64'h1);
    check({62'h0, diag_flags}, 64'h3);
    bus(1'b0, psbe_pkg::OFS_DIAG_FLAGS, 33'h3, 32'h0);
    bus(1'b0, psbe_pkg::OFS_DIAG_NEWEST, 33'hA5A50001, 32'h0);
    bus(1'b0, psbe_pkg::OFS_DIAG_FLAGS, 33'h2, 32'h0);
    bus(1'b0, psbe_pkg::OFS_IRQ_STATUS, 33'h1, 32'h0);
    check({63'h0, irq}, 64'h0);
    bus(1'b1, psbe_pkg::OFS_DIAG_ACK, IGN, 32'h1);
    bus(1'b0, psbe_pkg::OFS_DIAG_FLAGS, 33'h0, 32'h0);
    for (int i = 0; i < 251; i++) begin
      rnd = nx(rnd);
      push(rnd);
    end
    bus(1'b0, psbe_pkg::OFS_DIAG_NEWEST, {1'b0, rnd}, 32'h0);
    bus(1'b0, psbe_pkg::OFS_DIAG_COUNT, 33'hFA, 32'h0);
    bus(1'b1, psbe_pkg::OFS_IRQ_MASK, IGN, 32'h4);
    bus(1'b0, psbe_pkg::OFS_IRQ_STATUS, IGN, 32'h0);
    bus(1'b1, psbe_pkg::OFS_TIME_CTRL, IGN, 32'h2);
    bus(1'b0, psbe_pkg::OFS_TIME_CTRL, 33'h2, 32'h0);
    // Value near the top so the counter wraps two steps later
    tmsg(32'hFFFFFFC0);
    check({63'h0, time_msg_out}, 64'h1);
    check({32'h0, time_msg_fwd}, 64'hFFFFFFC0);
    repeat (4) @(posedge clk);
    check({63'h0, irq}, 64'h1);
    bus(1'b0, psbe_pkg::OFS_IRQ_STATUS, 33'h4, 32'h0);
    // Adopt a time twenty steps below the wrap, then switch to reference
    tmsg(32'hFFFFFC19);
    bus(1'b1, psbe_pkg::OFS_TIME_CTRL, IGN, 32'h1);
    // As reference with forwarding off, a received message is neither adopted nor forwarded
    tmsg(32'h12345678);
    check({63'h0, time_msg_out}, 64'h0);
    // Bounded wait for the reference's own pulse at the wrap
    repeat (40) if (time_msg_out !== 1'b1) @(posedge clk);
    check({63'h0, time_msg_out}, 64'h1);
    check({32'h0, time_msg_fwd}, 64'h1);
    bus(1'b1, psbe_pkg::OFS_TIME_CTRL, IGN, 32'h0);
    tmsg(32'h0);
    check({63'h0, time_msg_out}, 64'h0);
    stop_test;
  end
endmodule
`default_nettype wire
